// ===== src/jtag_tap.v
// Purpose: test access port with output steering to the core debug port
// Assumes: test pins are sampled by MCLK, far faster than the test clock
// Notes: boundary updates leave through a small fifo;
//   an update meeting a full fifo defers test clock edges until a word leaves and frees a slot
`include "tap_map.vh"
module jtag_tap (
  input wire MCLK,
  input wire RST_N,
  input wire TCK,
  input wire TMS,
  input wire TDI,
  input wire TRST_N,
  input wire CORE_TDO,
  output reg TDO_OUT,
  output reg TDO_OE,
  output reg CORE_SEL,
  output reg [3:0] TAP_STATE,
  input wire [`BS_W-1:0] BS_IN,
  output reg [`BS_W-1:0] BS_OUT,
  output reg BS_DRIVE,
  output reg BS_INTEST,
  output wire UPD_VALID,
  input wire UPD_READY,
  output wire [`BS_W-1:0] UPD_DATA
);
  localparam TLR = 4'h0;
  localparam RTI = 4'h1;
  localparam SEL_DR = 4'h2;
  localparam CAP_DR = 4'h3;
  localparam SH_DR = 4'h4;
  localparam EX1_DR = 4'h5;
  localparam PA_DR = 4'h6;
  localparam EX2_DR = 4'h7;
  localparam UPD_DR = 4'h8;
  localparam SEL_IR = 4'h9;
  localparam CAP_IR = 4'ha;
  localparam SH_IR = 4'hb;
  localparam EX1_IR = 4'hc;
  localparam PA_IR = 4'hd;
  localparam EX2_IR = 4'he;
  localparam UPD_IR = 4'hf;

  // pin synchronisers: {core tdo, tdi, tms, tck}
  reg [3:0] pin1_reg;
  reg [3:0] pin2_reg;
  reg [`BS_W-1:0] bs1_reg;
  reg [`BS_W-1:0] bs2_reg;
  reg tck_d_reg;
  reg [1:0] trst_reg;
  wire tap_arst_n;
  wire tap_rst_n;
  wire tck_s;
  wire tms_s;
  wire tdi_s;
  wire core_tdo_s;

  // tap state and chains
  reg [3:0] state_reg;
  reg [3:0] state_next;
  reg [`IR_W-1:0] ir_sh_reg;
  reg [`IR_W-1:0] ir_reg;
  reg [`ID_W-1:0] id_sh_reg;
  reg [`BS_W-1:0] bs_sh_reg;
  reg byp_reg;
  reg upd_pend_reg;
  reg rise_pend_reg;
  reg fall_pend_reg;
  wire tck_rise;
  wire tck_fall;
  wire stall;
  wire rise_go;
  wire fall_go;
  wire fifo_ready;

  // instruction decode
  wire is_idcode;
  wire is_sample;
  wire is_ext;
  wire is_int;
  wire is_core;
  wire is_bypass;
  reg dr_out;

  assign tck_s = pin2_reg[0];
  assign tms_s = pin2_reg[1];
  assign tdi_s = pin2_reg[2];
  assign core_tdo_s = pin2_reg[3];

  // power-on reset or test reset clears the tap at once
  assign tap_arst_n = RST_N & TRST_N;
  assign tap_rst_n = trst_reg[1];

  always @(posedge MCLK or negedge tap_arst_n) begin
    if (!tap_arst_n) begin
      trst_reg <= 2'h0;
    end else begin
      trst_reg <= {trst_reg[0], 1'b1};
    end
  end

  always @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      // idle levels of the pulled-up pins, so no false edge after reset
      pin1_reg <= 4'h7;
      pin2_reg <= 4'h7;
      bs1_reg <= {`BS_W{1'b0}};
      bs2_reg <= {`BS_W{1'b0}};
      tck_d_reg <= 1'b1;
    end else begin
      pin1_reg <= {CORE_TDO, TDI, TMS, TCK};
      pin2_reg <= pin1_reg;
      bs1_reg <= BS_IN;
      bs2_reg <= bs1_reg;
      tck_d_reg <= tck_s;
    end
  end

  // no edge on a stopped test clock, so nothing moves
  assign tck_rise = tck_s & ~tck_d_reg;
  assign tck_fall = ~tck_s & tck_d_reg;

  // a full fifo holds a pending update and defers the next edges;
  // a deferred fall waits until its rise has been handled
  assign stall = upd_pend_reg & ~fifo_ready;
  assign rise_go = (tck_rise | rise_pend_reg) & ~stall;
  assign fall_go = (tck_fall | fall_pend_reg) & ~stall & ~rise_pend_reg;

  assign is_idcode = (ir_reg == `INSTR_IDCODE);
  assign is_sample = (ir_reg == `INSTR_SAMPLE);
  assign is_ext = (ir_reg == `INSTR_EXTEST);
  assign is_int = (ir_reg == `INSTR_INTEST);
  assign is_core = (ir_reg == `ACCESS_PORT_ACCESS_INSTR) |
                   (ir_reg == `DEBUG_PORT_ACCESS_INSTR) |
                   (ir_reg == `INSTR_ABORT);
  // every other code falls back to the one-bit path
  assign is_bypass = ~(is_idcode | is_sample | is_core);

  // sixteen-state transition graph
  always @* begin
    state_next = state_reg;
    case (state_reg)
      TLR: begin
        state_next = tms_s ? TLR : RTI;
      end
      RTI: begin
        state_next = tms_s ? SEL_DR : RTI;
      end
      SEL_DR: begin
        state_next = tms_s ? SEL_IR : CAP_DR;
      end
      CAP_DR: begin
        state_next = tms_s ? EX1_DR : SH_DR;
      end
      SH_DR: begin
        state_next = tms_s ? EX1_DR : SH_DR;
      end
      EX1_DR: begin
        state_next = tms_s ? UPD_DR : PA_DR;
      end
      PA_DR: begin
        state_next = tms_s ? EX2_DR : PA_DR;
      end
      EX2_DR: begin
        state_next = tms_s ? UPD_DR : SH_DR;
      end
      UPD_DR: begin
        state_next = tms_s ? SEL_DR : RTI;
      end
      SEL_IR: begin
        state_next = tms_s ? TLR : CAP_IR;
      end
      CAP_IR: begin
        state_next = tms_s ? EX1_IR : SH_IR;
      end
      SH_IR: begin
        state_next = tms_s ? EX1_IR : SH_IR;
      end
      EX1_IR: begin
        state_next = tms_s ? UPD_IR : PA_IR;
      end
      PA_IR: begin
        state_next = tms_s ? EX2_IR : PA_IR;
      end
      EX2_IR: begin
        state_next = tms_s ? UPD_IR : SH_IR;
      end
      UPD_IR: begin
        state_next = tms_s ? SEL_DR : RTI;
      end
      default: begin
        state_next = TLR;
      end
    endcase
  end

  // bit leaving the selected data chain
  always @* begin
    if (is_idcode) begin
      dr_out = id_sh_reg[0];
    end else if (is_sample) begin
      dr_out = bs_sh_reg[0];
    end else if (is_core) begin
      dr_out = core_tdo_s;
    end else begin
      dr_out = byp_reg;
    end
  end

  // rising edge: state step, capture, shift and update
  always @(posedge MCLK or negedge tap_rst_n) begin
    if (!tap_rst_n) begin
      state_reg <= TLR;
      ir_sh_reg <= {`IR_W{1'b0}};
      ir_reg <= `INSTR_IDCODE;
      id_sh_reg <= {`ID_W{1'b0}};
      bs_sh_reg <= {`BS_W{1'b0}};
      byp_reg <= 1'b0;
      BS_OUT <= {`BS_W{1'b0}};
      upd_pend_reg <= 1'b0;
      rise_pend_reg <= 1'b0;
      fall_pend_reg <= 1'b0;
    end else begin
      if (tck_fall && (stall || rise_pend_reg)) begin
        fall_pend_reg <= 1'b1;
      end else if (fall_go) begin
        fall_pend_reg <= 1'b0;
      end
      if (stall && tck_rise) begin
        rise_pend_reg <= 1'b1;
      end else if (rise_go) begin
        rise_pend_reg <= 1'b0;
      end
      if (upd_pend_reg && fifo_ready) begin
        upd_pend_reg <= 1'b0;
      end
      if (rise_go) begin
        state_reg <= state_next;
        case (state_reg)
          TLR: begin
            ir_reg <= `INSTR_IDCODE;
          end
          CAP_IR: begin
            ir_sh_reg <= `IR_CAPTURE;
          end
          SH_IR: begin
            ir_sh_reg <= {tdi_s, ir_sh_reg[`IR_W-1:1]};
          end
          UPD_IR: begin
            ir_reg <= ir_sh_reg;
          end
          CAP_DR: begin
            if (is_idcode) begin
              id_sh_reg <= `ID_VALUE;
            end
            if (is_sample) begin
              bs_sh_reg <= bs2_reg;
            end
            if (is_bypass) begin
              byp_reg <= 1'b0;
            end
          end
          SH_DR: begin
            if (is_idcode) begin
              id_sh_reg <= {tdi_s, id_sh_reg[`ID_W-1:1]};
            end
            if (is_sample) begin
              bs_sh_reg <= {tdi_s, bs_sh_reg[`BS_W-1:1]};
            end
            if (is_bypass) begin
              byp_reg <= tdi_s;
            end
          end
          UPD_DR: begin
            if (is_sample) begin
              BS_OUT <= bs_sh_reg;
              upd_pend_reg <= 1'b1;
            end
          end
          default: begin
            ir_reg <= ir_reg;
          end
        endcase
        // entering reset drops the old instruction at once
        if (state_next == TLR) begin
          ir_reg <= `INSTR_IDCODE;
        end
      end
    end
  end

  // falling edge: output bit, enable and steering change here
  always @(posedge MCLK or negedge tap_rst_n) begin
    if (!tap_rst_n) begin
      TDO_OUT <= 1'b0;
      TDO_OE <= 1'b0;
      CORE_SEL <= 1'b0;
      BS_DRIVE <= 1'b0;
      BS_INTEST <= 1'b0;
      TAP_STATE <= TLR;
    end else begin
      TAP_STATE <= state_reg;
      BS_DRIVE <= is_ext;
      BS_INTEST <= is_int;
      if (fall_go) begin
        CORE_SEL <= is_core;
        TDO_OE <= (state_reg == SH_IR) | (state_reg == SH_DR);
        if (state_reg == SH_IR) begin
          TDO_OUT <= ir_sh_reg[0];
        end else if (state_reg == SH_DR) begin
          TDO_OUT <= dr_out;
        end
      end
    end
  end

  // boundary update words leave through the fifo
  tap_fifo #(
    .W(`BS_W),
    .DEPTH(`FIFO_DEPTH),
    .AW(`FIFO_AW)
  ) upd_fifo (
    .clk(MCLK),
    .rst_n(tap_rst_n),
    .in_valid(upd_pend_reg),
    .in_ready(fifo_ready),
    .in_data(BS_OUT),
    .out_valid(UPD_VALID),
    .out_ready(UPD_READY),
    .out_data(UPD_DATA)
  );
endmodule // jtag_tap

// ===== src/tap_map.vh
// What this block does
// - step state on each rising test clock
// - test reset acts at once, no clock
// - held test reset keeps Test-Logic-Reset
// - Test-Logic-Reset loads the IDCODE instruction
// - five high mode-selects reach Test-Logic-Reset
// - stopped test clock keeps all state
// - four-bit instruction chain plus update register
// - held instruction picks the data chain
// - TAP state times capture, shift, update
// - unknown instruction codes act as BYPASS
// - EXTEST and INTEST shift the one-bit bypass chain, not the boundary chain
// - instruction picks core or vendor output
// - standard plus core debug instructions
// - power-on reset also resets the TAP
// - data input sampled on rising edge
// - data output driven only while shifting
// - data output changes on falling edge
//
// Purpose: constants of the test access port
// Assumes: included by bare name, no other definitions
// Notes: instruction codes and id value are arbitrary
`ifndef TAP_MAP_VH
`define TAP_MAP_VH
`define IR_W 4
`define IR_CAPTURE 4'h1
`define INSTR_EXTEST 4'h0
`define INSTR_INTEST 4'h1
`define INSTR_SAMPLE 4'h2
`define INSTR_ABORT 4'h8
`define DEBUG_PORT_ACCESS_INSTR 4'ha
`define ACCESS_PORT_ACCESS_INSTR 4'hb
`define INSTR_IDCODE 4'he
`define INSTR_BYPASS 4'hf
`define ID_W 32
// arbitrary identification value
`define ID_VALUE 32'h00001001
`define BS_W 8
`define FIFO_DEPTH 4
`define FIFO_AW 2
`endif

// ===== src/tap_fifo.v
// Purpose: small word fifo with valid and ready on both sides
// Assumes: one clock, asynchronous active-low reset
// Notes: depth must be a power of two equal to 2**AW
module tap_fifo #(
  parameter W = 8,
  parameter DEPTH = 4,
  parameter AW = 2
) (
  input wire clk,
  input wire rst_n,
  input wire in_valid,
  output wire in_ready,
  input wire [W-1:0] in_data,
  output wire out_valid,
  input wire out_ready,
  output wire [W-1:0] out_data
);
  reg [W-1:0] mem_reg [0:DEPTH-1];
  reg [AW-1:0] wr_reg;
  reg [AW-1:0] rd_reg;
  reg [AW:0] cnt_reg;
  wire push;
  wire pop;
  integer i;

  assign in_ready = ~cnt_reg[AW];
  assign out_valid = (cnt_reg != {(AW+1){1'b0}});
  assign out_data = mem_reg[rd_reg];
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_reg <= {AW{1'b0}};
      rd_reg <= {AW{1'b0}};
      cnt_reg <= {(AW+1){1'b0}};
      for (i = 0; i < DEPTH; i = i + 1) begin
        mem_reg[i] <= {W{1'b0}};
      end
    end else begin
      if (push) begin
        mem_reg[wr_reg] <= in_data;
        wr_reg <= wr_reg + {{(AW-1){1'b0}}, 1'b1};
      end
      if (pop) begin
        rd_reg <= rd_reg + {{(AW-1){1'b0}}, 1'b1};
      end
      if (push && !pop) begin
        cnt_reg <= cnt_reg + {{AW{1'b0}}, 1'b1};
      end else if (pop && !push) begin
        cnt_reg <= cnt_reg - {{AW{1'b0}}, 1'b1};
      end
    end
  end
endmodule // tap_fifo

// ===== verif/jtag_host.sv
// Purpose: test host model driving the tap pins
// Assumes: tck stands low between frames
// Notes: pins change at mclk falls
module jtag_host (
  input wire logic clk,
  input wire logic tdo,
  output logic tck,
  output logic tms,
  output logic tdi
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b1;
  end
  // one test clock period, tdo read at the rise
  task automatic step(input logic m, input logic d, output logic q);
    @(negedge clk);
    tms = m;
    tdi = d;
    #80 tck = 1'b1;
    q = tdo;
    #80 tck = 1'b0;
  endtask
  // from idle through capture, shift, update back to idle
  task automatic scan(input logic ir, input int n,
      input logic [31:0] din, output logic [31:0] dout);
    logic q;
    step(1'b1, 1'b1, q);
    if (ir)
      step(1'b1, 1'b1, q);
    step(1'b0, 1'b1, q);
    step(1'b0, 1'b1, q);
    dout = '0;
    for (int i = 0; i < n; i++) begin
      step(i == n - 1, din[i], q);
      dout[i] = q;
    end
    step(1'b1, 1'b1, q);
    step(1'b0, 1'b1, q);
  endtask
  task automatic reset5();
    logic q;
    repeat (5) step(1'b1, 1'b1, q);
    step(1'b0, 1'b1, q);
  endtask
endmodule // jtag_host

// ===== verif/jtag_tap_assertions.sv
// Purpose: port checks of the test access port
// Assumes: test clock far slower than mclk
// Notes: bound to the design below
`include "tap_map.vh"
module jtag_tap_assertions (
  input wire logic MCLK,
  input wire logic RST_N,
  input wire logic TCK,
  input wire logic TRST_N,
  input wire logic TDO_OUT,
  input wire logic TDO_OE,
  input wire logic CORE_SEL,
  input wire logic [3:0] TAP_STATE,
  input wire logic [`BS_W-1:0] BS_OUT,
  input wire logic BS_DRIVE,
  input wire logic BS_INTEST,
  input wire logic UPD_VALID,
  input wire logic UPD_READY,
  input wire logic [`BS_W-1:0] UPD_DATA
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge MCLK); endclocking
  default disable iff (!RST_N);
  sequence s_tlr8;
    (TAP_STATE == 4'h0) [*8];
  endsequence
  sequence s_rti4;
    (TAP_STATE == 4'h1) [*4];
  endsequence
  a_trst_holds_tlr: assert property (
    !TRST_N |-> TAP_STATE == 4'h0) else $error("tap left reset");
  a_step_at_rise: assert property (
    $changed(TAP_STATE) && TRST_N && $past(TRST_N) |-> TCK)
    else $error("state moved with test clock low");
  a_tdo_at_fall: assert property (
    $changed(TDO_OUT) && TRST_N |-> !TCK)
    else $error("data out moved with test clock high");
  a_oe_in_shift: assert property (
    $rose(TDO_OE) |-> TAP_STATE == 4'h4 || TAP_STATE == 4'hb)
    else $error("output enabled outside shift");
  a_oe_idle_off: assert property (
    s_rti4 |-> !TDO_OE) else $error("output driven in idle");
  a_tlr_loads_id: assert property (
    s_tlr8 ##1 s_tlr8 |-> !CORE_SEL && !BS_DRIVE && !BS_INTEST)
    else $error("reset instruction not loaded");
  a_fifo_word_held: assert property (
    UPD_VALID && !UPD_READY && TRST_N |=>
    !TRST_N || UPD_VALID && $stable(UPD_DATA))
    else $error("waiting word lost");
  a_extest_frozen: assert property (
    BS_DRIVE && $past(BS_DRIVE) |-> $stable(BS_OUT))
    else $error("boundary changed under extest");
endmodule // jtag_tap_assertions

bind jtag_tap jtag_tap_assertions u_chk (.MCLK, .RST_N, .TCK, .TRST_N,
  .TDO_OUT, .TDO_OE, .CORE_SEL, .TAP_STATE, .BS_OUT, .BS_DRIVE,
  .BS_INTEST, .UPD_VALID, .UPD_READY, .UPD_DATA);

// ===== verif/jtag_tap_with_tdo_mux_test.sv
// Purpose: self-checking bench of the test access port
// Assumes: host model owns the test clock
// Notes: tdo line has a pull-up
`include "tap_map.vh"
module jtag_tap_with_tdo_mux_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic trst_n = 1'b1;
  logic core_tdo = 1'b0;
  logic upd_ready = 1'b0;
  logic [7:0] bs_in = 8'h00;
  logic [31:0] r;
  int n_fail = 0;
  int checks = 0;
  int cycles = 0;
  wire tck, tms, tdi, tdo_out, tdo_oe, core_sel;
  wire bs_drive, bs_intest, upd_valid;
  wire [3:0] tap_state;
  wire [7:0] bs_out, upd_data;
  wire tdo_line = tdo_oe ? tdo_out : 1'b1;
  always #5 mclk = ~mclk;
  jtag_host u_host (.clk(mclk), .tdo(tdo_line), .tck(tck), .tms(tms),
    .tdi(tdi));
  jtag_tap u_dut (.MCLK(mclk), .RST_N(rst_n), .TCK(tck), .TMS(tms),
    .TDI(tdi), .TRST_N(trst_n), .CORE_TDO(core_tdo), .TDO_OUT(tdo_out),
    .TDO_OE(tdo_oe), .CORE_SEL(core_sel), .TAP_STATE(tap_state),
    .BS_IN(bs_in), .BS_OUT(bs_out), .BS_DRIVE(bs_drive),
    .BS_INTEST(bs_intest), .UPD_VALID(upd_valid),
    .UPD_READY(upd_ready), .UPD_DATA(upd_data));
  task automatic test_done();
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 60000) begin
      n_fail++;
      test_done();
    end
  end
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic ir(input logic [3:0] c);
    u_host.scan(1'b1, 4, {28'h0, c}, r);
    // steering follows the detected fall a few clocks later
    repeat (6) @(negedge mclk);
    chk(r[3:0], `IR_CAPTURE);
  endtask
  task automatic t_idcode();
    u_host.scan(1'b0, 32, 32'h0, r);
    chk({r, tdo_oe}, {`ID_VALUE, 1'b0});
  endtask
  task automatic t_bypass();
    logic [3:0] c[4] = '{4'h3, 4'h6, 4'hc, `INSTR_BYPASS};
    foreach (c[k]) begin
      ir(c[k]);
      u_host.scan(1'b0, 2, 32'h1, r);
      chk(r[1:0], 2'b10);
    end
  endtask
  task automatic t_core();
    logic [3:0] c[3] = '{`DEBUG_PORT_ACCESS_INSTR,
      `ACCESS_PORT_ACCESS_INSTR, `INSTR_ABORT};
    foreach (c[k]) begin
      @(negedge mclk) core_tdo = k[0];
      ir(c[k]);
      chk(core_sel, 1'b1);
      u_host.scan(1'b0, 4, 32'h0, r);
      chk(r[3:0], {4{k[0]}});
    end
    ir(`INSTR_IDCODE);
    chk(core_sel, 1'b0);
  endtask
  task automatic t_sample();
    @(negedge mclk) bs_in = 8'h5a;
    ir(`INSTR_SAMPLE);
    u_host.scan(1'b0, 8, 32'hc3, r);
    chk({r[7:0], bs_out}, 16'h5ac3);
    u_host.scan(1'b0, 8, 32'h3c, r);
    chk({upd_valid, upd_data}, 9'h1c3);
    @(negedge mclk) upd_ready = 1'b1;
    @(negedge mclk) chk({upd_valid, upd_data}, 9'h13c);
    @(negedge mclk) chk(upd_valid, 1'b0);
  endtask
  task automatic t_extest();
    ir(`INSTR_EXTEST);
    chk({bs_drive, bs_intest}, 2'b10);
    u_host.scan(1'b0, 2, 32'h3, r);
    chk({r[1:0], bs_out}, 10'h23c);
    ir(`INSTR_INTEST);
    chk({bs_drive, bs_intest}, 2'b01);
  endtask
  task automatic t_trst();
    logic q;
    u_host.step(1'b1, 1'b1, q);
    u_host.step(1'b0, 1'b1, q);
    u_host.step(1'b0, 1'b1, q);
    repeat (6) @(negedge mclk);
    chk({tap_state, tdo_oe}, 5'h09);
    @(negedge mclk) trst_n = 1'b0;
    @(negedge mclk) chk(tap_state, 4'h0);
    u_host.step(1'b0, 1'b1, q);
    chk(tap_state, 4'h0);
    @(negedge mclk) trst_n = 1'b1;
    repeat (4) @(negedge mclk);
    u_host.step(1'b0, 1'b1, q);
    t_idcode();
  endtask
  task automatic t_tms5();
    logic q;
    ir(`DEBUG_PORT_ACCESS_INSTR);
    u_host.step(1'b1, 1'b1, q);
    u_host.step(1'b0, 1'b1, q);
    u_host.reset5();
    repeat (300) @(negedge mclk);
    chk(tap_state, 4'h1);
    chk(core_sel, 1'b0);
    t_idcode();
  endtask
  initial begin
    repeat (8) @(negedge mclk);
    rst_n = 1'b1;
    repeat (4) @(negedge mclk);
    chk(tap_state, 4'h0);
    u_host.reset5();
    t_idcode();
    t_bypass();
    t_core();
    t_sample();
    t_extest();
    t_trst();
    t_tms5();
    test_done();
  end
endmodule // jtag_tap_with_tdo_mux_test
